//--- logic/apc_pkg.sv
// Constants, register map and carrier types for the axis positioning controller.
// Assumes a 40 MHz APB clock shared by the whole block.
package apc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned NS_PER_S = 1000000000;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CLK_HZ = NS_PER_S / CLK_PERIOD_NS;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned BRAKE_NUM = 2000;
  localparam int unsigned SYNC_LAT = 3;

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int unsigned TBL_ENTRIES = 10;
  localparam int unsigned NUM_W = 4;
  localparam int unsigned SPEED_W = 18;
  localparam int unsigned TIME_W = 15;
  localparam int unsigned DWELL_W = 16;
  localparam int unsigned POS_W = 32;
  localparam int unsigned FEED_HALF = 16;
  localparam int unsigned PH_W = 27;
  localparam logic [SPEED_W-1:0] SPEED_MAX = 18'h30d40;
  localparam logic [SPEED_W-1:0] BIAS_RST = 18'h00000;

  // ****************************************
  // Register offsets and control bits
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FEED_LO = 8'h08;
  localparam logic [7:0] OFF_FEED_HI = 8'h0c;
  localparam logic [7:0] OFF_BIAS = 8'h10;
  localparam logic [7:0] OFF_LIMIT = 8'h14;
  localparam logic [7:0] OFF_CFG = 8'h18;
  localparam logic [7:0] OFF_GPIO = 8'h1c;
  localparam logic [7:0] OFF_METHOD = 8'h20;
  localparam logic [7:0] OFF_ACC = 8'h24;
  localparam logic [7:0] OFF_DEC = 8'h28;
  localparam logic [7:0] OFF_DWELL = 8'h2c;
  localparam logic [7:0] OFF_SPEED = 8'h30;
  localparam logic [7:0] OFF_TARGET = 8'h34;
  localparam logic [7:0] OFF_TSEL = 8'h38;
  localparam logic [7:0] OFF_TCOMMIT = 8'h3c;
  localparam int unsigned CTL_TBL = 0;
  localparam int unsigned CTL_DEV = 1;
  localparam int unsigned CTL_DUAL = 2;
  localparam int unsigned CTL_STOP = 3;
  localparam int unsigned CTL_NUM_LSB = 4;

  // ****************************************
  // Control methods and states
  // ****************************************
  localparam logic [2:0] M_NONE = 3'h0;
  localparam logic [2:0] M_ABS = 3'h1;
  localparam logic [2:0] M_INC = 3'h2;
  localparam logic [2:0] M_SPF = 3'h3;
  localparam logic [2:0] M_SPR = 3'h4;
  localparam logic [2:0] M_CHG = 3'h5;
  localparam logic [2:0] M_SVF = 3'h6;
  localparam logic [2:0] M_SVR = 3'h7;

  typedef enum {ST_IDLE, ST_RUN, ST_DECEL, ST_DWELL} apc_state_t;

  typedef struct packed {
    logic [2:0] method;
    logic [TIME_W-1:0] acc_ms;
    logic [TIME_W-1:0] dec_ms;
    logic [DWELL_W-1:0] dwell_ms;
    logic [SPEED_W-1:0] speed;
    logic [POS_W-1:0] target;
  } apc_entry_t;

  typedef struct packed {
    logic gp_out;
    logic rdy_en;
    logic lim_en;
    logic cw_ccw;
  } apc_cfg_t;

  typedef struct packed {
    logic partner;
    logic tool_en;
    logic ext;
    logic lower;
    logic upper;
    logic ready;
    logic dog;
    logic origin;
  } apc_pins_t;

endpackage : apc_pkg

//--- logic/apc_axis_ctrl.sv
// Single-axis pulse/direction positioning controller with APB registers.
// Assumes pins arrive asynchronously and a partner axis shares the sync strobe.
//
// What this block does
// - Method none produces no motion
// - Position control moves to target, stops
// - Constant speed, then exact amount after command
// - Current value change overwrites feed, no pulses
// - Speed control runs until stop command
// - Ramp bias to command speed over acceleration
// - Ramp down to bias on end or stop
// - Complete flag only after dwell elapses
// - Speed above limit runs at limit
// - Speed below bias runs at bias
// - Absolute and change targets reference origin
// - Incremental amount is signed, sign gives direction
// - Speed control ignores target value
// - Unused control pins serve as general I/O
// - Ten stored entries per axis, tool loaded
// - Program cannot modify stored entries
// - Table start picks entry by number
// - Stored-data starts may start both axes together
// - Device-data start takes fresh data, single axis
// - Ramp times to 32767 ms, dwell to 65535 ms, speed to 200000
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module apc_axis_ctrl
  import apc_pkg::*;
#(
  parameter int unsigned NUM_ENTRIES = TBL_ENTRIES,
  parameter int unsigned CYC_MS = CYC_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tool_load_en,
  input wire logic origin_in,
  input wire logic dog_in,
  input wire logic drive_ready_in,
  input wire logic upper_lim_in,
  input wire logic lower_lim_in,
  input wire logic ext_cmd_in,
  input wire logic sync_start_i,
  output logic sync_start_o,
  output logic dev_clear_o,
  output logic pulse_out_a,
  output logic pulse_out_b,
  output logic positioning_complete_flag
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  apc_pins_t raw;
  apc_pins_t meta_q;
  apc_pins_t sync_q;
  logic ext_q;
  logic partner_q;

  assign raw = apc_pins_t'({sync_start_i, tool_load_en, ext_cmd_in, lower_lim_in, upper_lim_in,
                            drive_ready_in, dog_in, origin_in});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
      ext_q <= 1'b0;
      partner_q <= 1'b0;
    end else if (ce) begin
      meta_q <= raw;
      sync_q <= meta_q;
      ext_q <= sync_q.ext;
      partner_q <= sync_q.partner;
    end
  end

  // ****************************************
  // APB registers
  // ****************************************
  logic wr;
  logic ctrl_wr;
  logic hit;
  logic [31:0] rd_d;
  logic [31:0] prdata_q;
  apc_cfg_t cfg_q;
  logic [SPEED_W-1:0] bias_q;
  logic [SPEED_W-1:0] limit_q;
  apc_entry_t stage_q;
  logic [NUM_W-1:0] tsel_q;
  logic [NUM_W-1:0] num_q;
  apc_entry_t table_q [NUM_ENTRIES];
  apc_state_t state_q;
  logic done_q;
  logic dir_q;
  logic posn_q;
  logic stopping_q;
  logic [POS_W-1:0] feed_q;

  assign wr = ce && psel && penable && pwrite;
  assign ctrl_wr = wr && paddr == OFF_CTRL;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;

  function automatic logic [SPEED_W-1:0] sat_speed(input logic [31:0] v);
    sat_speed = (v > 32'(SPEED_MAX)) ? SPEED_MAX : v[SPEED_W-1:0];
  endfunction : sat_speed

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
      bias_q <= BIAS_RST;
      limit_q <= SPEED_MAX;
      stage_q <= '0;
      tsel_q <= '0;
      num_q <= '0;
    end else if (wr) begin
      case (paddr)
        OFF_CTRL: num_q <= pwdata[CTL_NUM_LSB +: NUM_W];
        OFF_BIAS: bias_q <= sat_speed(pwdata);
        OFF_LIMIT: limit_q <= sat_speed(pwdata);
        OFF_CFG: cfg_q <= apc_cfg_t'(pwdata[$bits(apc_cfg_t)-1:0]);
        OFF_METHOD: stage_q.method <= pwdata[2:0];
        OFF_ACC: stage_q.acc_ms <= pwdata[TIME_W-1:0];
        OFF_DEC: stage_q.dec_ms <= pwdata[TIME_W-1:0];
        OFF_DWELL: stage_q.dwell_ms <= pwdata[DWELL_W-1:0];
        OFF_SPEED: stage_q.speed <= sat_speed(pwdata);
        OFF_TARGET: stage_q.target <= pwdata;
        OFF_TSEL: tsel_q <= pwdata[NUM_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Stored entries change only while the tool load strap is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_ENTRIES; i++) begin
        table_q[i] <= '0;
      end
    end else if (wr && paddr == OFF_TCOMMIT && sync_q.tool_en && tsel_q < NUM_W'(NUM_ENTRIES)) begin
      table_q[tsel_q] <= stage_q;
    end
  end

  always_comb begin
    rd_d = '0;
    hit = 1'b1;
    case (paddr)
      OFF_CTRL: rd_d = 32'(num_q);
      OFF_STATUS: rd_d = 32'({stopping_q, posn_q, dir_q, state_q != ST_IDLE, done_q});
      OFF_FEED_LO: rd_d = 32'(feed_q[FEED_HALF-1:0]);
      OFF_FEED_HI: rd_d = 32'(feed_q[POS_W-1:FEED_HALF]);
      OFF_BIAS: rd_d = 32'(bias_q);
      OFF_LIMIT: rd_d = 32'(limit_q);
      OFF_CFG: rd_d = 32'(cfg_q);
      OFF_GPIO: rd_d = 32'(sync_q);
      OFF_METHOD: rd_d = 32'(stage_q.method);
      OFF_ACC: rd_d = 32'(stage_q.acc_ms);
      OFF_DEC: rd_d = 32'(stage_q.dec_ms);
      OFF_DWELL: rd_d = 32'(stage_q.dwell_ms);
      OFF_SPEED: rd_d = 32'(stage_q.speed);
      OFF_TARGET: rd_d = stage_q.target;
      OFF_TSEL: rd_d = 32'(tsel_q);
      OFF_TCOMMIT: rd_d = '0;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (ce && psel && !penable) begin
      prdata_q <= rd_d;
    end
  end

  // ****************************************
  // Start requests
  // ****************************************
  logic tbl_req_q;
  logic dev_req_q;
  logic sync_o_q;
  logic [SYNC_LAT-1:0] dly_q;
  logic go_tbl;
  logic go_ok;
  logic stop_req;
  apc_entry_t ent;
  logic [SPEED_W-1:0] sp_lim;
  logic [SPEED_W-1:0] sp_c;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_req_q <= 1'b0;
      dev_req_q <= 1'b0;
      sync_o_q <= 1'b0;
      dly_q <= '0;
    end else if (ce) begin
      tbl_req_q <= ctrl_wr && pwdata[CTL_TBL];
      dev_req_q <= ctrl_wr && pwdata[CTL_DEV];
      sync_o_q <= ctrl_wr && pwdata[CTL_DUAL];
      dly_q <= {dly_q[SYNC_LAT-2:0], ctrl_wr && pwdata[CTL_DUAL]};
    end
  end

  assign sync_start_o = sync_o_q;
  assign stop_req = ctrl_wr && pwdata[CTL_STOP];
  // Own start is delayed to match the partner's synchroniser latency
  assign go_tbl = tbl_req_q || dly_q[SYNC_LAT-1] || (sync_q.partner && !partner_q);
  assign go_ok = ce && state_q == ST_IDLE && (dev_req_q || (go_tbl && num_q < NUM_W'(NUM_ENTRIES)));
  assign ent = dev_req_q ? stage_q : table_q[num_q];
  assign sp_lim = (ent.speed > limit_q) ? limit_q : ent.speed;
  assign sp_c = (sp_lim < bias_q) ? bias_q : sp_lim;

  // ****************************************
  // Motion engine
  // ****************************************
  apc_state_t state_d;
  logic [2:0] meth_q;
  logic [TIME_W-1:0] acc_t_q;
  logic [TIME_W-1:0] dec_t_q;
  logic [DWELL_W-1:0] dwell_q;
  logic [SPEED_W-1:0] sp_q;
  logic [SPEED_W-1:0] cur_q;
  logic [SPEED_W-1:0] eff;
  logic [31:0] err_q;
  logic [31:0] err_nx;
  logic [31:0] den;
  logic [POS_W-1:0] rem_q;
  logic [POS_W-1:0] diff;
  logic [PH_W-1:0] ph_q;
  logic [PH_W-1:0] ph_nx;
  logic lvl_q;
  logic moving;
  logic wrap;
  logic step;
  logic ramp_ev;
  logic fault;
  logic brake;
  logic sw_pos;
  logic [42:0] brake_l;
  logic [42:0] brake_r;
  logic [31:0] msc_q;
  logic [DWELL_W-1:0] dwc_q;
  logic tick;

  function automatic logic [POS_W-1:0] abs32(input logic [POS_W-1:0] v);
    abs32 = v[POS_W-1] ? (~v + POS_W'(1)) : v;
  endfunction : abs32

  assign moving = state_q == ST_RUN || state_q == ST_DECEL;
  assign eff = (posn_q && cur_q == '0) ? SPEED_W'(1) : cur_q;
  assign ph_nx = ph_q + PH_W'({eff, 1'b0});
  assign wrap = ph_nx >= PH_W'(CLK_HZ);
  assign step = moving && wrap && !lvl_q;
  assign den = (state_q == ST_DECEL ? 32'(dec_t_q) : 32'(acc_t_q)) * CYC_MS;
  assign err_nx = err_q + 32'(sp_q - bias_q);
  assign ramp_ev = err_nx >= den;
  assign diff = ent.target - feed_q;
  assign fault = (cfg_q.lim_en && (dir_q ? sync_q.upper : sync_q.lower))
              || (cfg_q.rdy_en && !sync_q.ready);
  assign brake_l = {11'h000, rem_q} * 43'(BRAKE_NUM);
  assign brake_r = 43'({1'b0, cur_q} + {1'b0, bias_q}) * 43'(dec_t_q);
  assign brake = posn_q && brake_l <= brake_r;
  assign sw_pos = !posn_q && (meth_q == M_SPF || meth_q == M_SPR) && sync_q.ext && !ext_q;
  assign tick = msc_q == CYC_MS - 32'd1;

  // Pulse rate generator, two phase steps per output pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= '0;
      lvl_q <= 1'b0;
    end else if (ce) begin
      if (!moving) begin
        ph_q <= '0;
        lvl_q <= 1'b0;
      end else if (wrap) begin
        ph_q <= ph_nx - PH_W'(CLK_HZ);
        lvl_q <= !lvl_q;
      end else begin
        ph_q <= ph_nx;
      end
    end
  end

  // Dwell millisecond timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msc_q <= '0;
      dwc_q <= '0;
    end else if (ce) begin
      if (state_q != ST_DWELL) begin
        msc_q <= '0;
        dwc_q <= '0;
      end else if (tick) begin
        msc_q <= '0;
        dwc_q <= dwc_q + DWELL_W'(1);
      end else begin
        msc_q <= msc_q + 32'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      meth_q <= M_NONE;
      acc_t_q <= '0;
      dec_t_q <= '0;
      dwell_q <= '0;
      sp_q <= '0;
      cur_q <= '0;
      err_q <= '0;
      rem_q <= '0;
      dir_q <= 1'b1;
      posn_q <= 1'b0;
      stopping_q <= 1'b0;
      feed_q <= '0;
      done_q <= 1'b0;
    end else if (ce) begin
      if (step && posn_q) begin
        rem_q <= rem_q - POS_W'(1);
        feed_q <= dir_q ? feed_q + POS_W'(1) : feed_q - POS_W'(1);
      end
      case (state_q)
        ST_IDLE: begin
          if (go_ok) begin
            meth_q <= ent.method;
            acc_t_q <= ent.acc_ms;
            dec_t_q <= ent.dec_ms;
            dwell_q <= ent.dwell_ms;
            sp_q <= sp_c;
            cur_q <= bias_q;
            err_q <= '0;
            stopping_q <= 1'b0;
            done_q <= 1'b0;
            case (ent.method)
              M_ABS: begin
                dir_q <= !diff[POS_W-1];
                rem_q <= abs32(diff);
                posn_q <= 1'b1;
                state_q <= (diff == '0) ? ST_DWELL : ST_RUN;
              end
              M_INC: begin
                dir_q <= !ent.target[POS_W-1];
                rem_q <= abs32(ent.target);
                posn_q <= 1'b1;
                state_q <= (ent.target == '0) ? ST_DWELL : ST_RUN;
              end
              M_SPF, M_SPR: begin
                dir_q <= ent.method == M_SPF;
                feed_q <= '0;
                rem_q <= ent.target[POS_W-1] ? '0 : ent.target;
                posn_q <= sync_q.ext;
                state_q <= ST_RUN;
              end
              M_CHG: begin
                feed_q <= ent.target;
                posn_q <= 1'b0;
                state_q <= ST_DWELL;
              end
              M_SVF, M_SVR: begin
                dir_q <= ent.method == M_SVF;
                feed_q <= '0;
                posn_q <= 1'b0;
                state_q <= ST_RUN;
              end
              default: state_q <= ST_IDLE;
            endcase
          end
        end
        ST_RUN: begin
          if (posn_q && rem_q == '0) begin
            cur_q <= '0;
            state_q <= ST_DWELL;
          end else if (stop_req || fault) begin
            stopping_q <= 1'b1;
            err_q <= '0;
            state_q <= ST_DECEL;
          end else if (brake) begin
            err_q <= '0;
            state_q <= ST_DECEL;
          end else if (sw_pos) begin
            posn_q <= 1'b1;
            if (cur_q < sp_q) begin
              sp_q <= cur_q;
            end
          end else if (cur_q > sp_q || den == '0) begin
            cur_q <= sp_q;
          end else if (cur_q < sp_q) begin
            if (ramp_ev) begin
              cur_q <= cur_q + SPEED_W'(1);
              err_q <= err_nx - den;
            end else begin
              err_q <= err_nx;
            end
          end
        end
        ST_DECEL: begin
          if (stop_req || fault) begin
            stopping_q <= 1'b1;
          end
          if (posn_q && rem_q == '0) begin
            cur_q <= '0;
            state_q <= stopping_q ? ST_IDLE : ST_DWELL;
          end else if (cur_q <= bias_q) begin
            if (stopping_q || !posn_q) begin
              cur_q <= '0;
              state_q <= ST_IDLE;
            end
          end else if (den == '0) begin
            cur_q <= bias_q;
          end else if (ramp_ev) begin
            cur_q <= cur_q - SPEED_W'(1);
            err_q <= err_nx - den;
          end else begin
            err_q <= err_nx;
          end
        end
        ST_DWELL: begin
          if (dwc_q >= dwell_q) begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  logic a_q;
  logic b_q;
  logic gp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      gp_q <= 1'b0;
    end else if (ce) begin
      a_q <= cfg_q.cw_ccw ? (dir_q && lvl_q) : lvl_q;
      b_q <= cfg_q.cw_ccw ? (!dir_q && lvl_q) : !dir_q;
      gp_q <= cfg_q.gp_out;
    end
  end

  assign pulse_out_a = a_q;
  assign pulse_out_b = b_q;
  assign dev_clear_o = gp_q;
  assign positioning_complete_flag = done_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_NONE_IDLE: assert property (go_ok && ent.method == M_NONE |=> state_q == ST_IDLE)
    else $error("none method left idle");
  AST_CHG_FEED: assert property (go_ok && ent.method == M_CHG |=> feed_q == $past(ent.target) ##1 !moving)
    else $error("current value change failed");
  AST_LIMIT: assert property (go_ok |=> sp_q <= $past(limit_q) || sp_q == $past(bias_q))
    else $error("speed above limit");
  AST_BIAS: assert property (go_ok |=> sp_q >= $past(bias_q))
    else $error("speed below bias");
  AST_DWELL: assert property ($rose(done_q) |-> $past(state_q) == ST_DWELL && $past(dwc_q) >= $past(dwell_q))
    else $error("complete before dwell");
  AST_STOP: assert property (ce && state_q == ST_RUN && stop_req && !(posn_q && rem_q == '0)
    |=> state_q == ST_DECEL)
    else $error("stop did not decelerate");
  AST_FEED_UP: assert property (ce && step && posn_q && dir_q |=> feed_q == $past(feed_q) + 32'd1)
    else $error("feed not advanced");
  AST_REV_DIR: assert property (state_q != ST_IDLE && meth_q == M_SVR |-> !dir_q)
    else $error("reverse run direction wrong");
  AST_SPEED_HOLD: assert property (ce && state_q == ST_RUN && meth_q == M_SVF && !stop_req && !fault
    |=> state_q == ST_RUN)
    else $error("speed control left run");

endmodule : apc_axis_ctrl

//--- tb/apc_drive_model.sv
// Drive unit model: counts motion pulses and holds the status pins.
// Assumes the bench mirrors the controller's pulse encoding on cw_ccw.
`timescale 1ns/1ps
module apc_drive_model (
  input wire logic pclk,
  input wire logic cw_ccw,
  input wire logic pulse_out_a,
  input wire logic pulse_out_b,
  output logic origin_in,
  output logic dog_in,
  output logic drive_ready_in,
  output logic upper_lim_in,
  output logic lower_lim_in,
  output int pos
);
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  // ****
  // Pins and position counter
  // ****
  assign origin_in = 1'b1;
  assign dog_in = 1'b0;
  assign drive_ready_in = 1'b1;
  assign upper_lim_in = 1'b0;
  assign lower_lim_in = 1'b0;
  always @(posedge pclk) begin
    a_q <= pulse_out_a;
    b_q <= pulse_out_b;
    if (cw_ccw) begin
      if (pulse_out_a && !a_q) begin
        pos <= pos + 1;
      end else if (pulse_out_b && !b_q) begin
        pos <= pos - 1;
      end
    end else if (pulse_out_a && !a_q) begin
      pos <= pulse_out_b ? pos - 1 : pos + 1;
    end
  end
endmodule : apc_drive_model

//--- tb/tb_axis_positioning_control.sv
// Self-checking bench for the axis positioning controller.
// Assumes the drive model on the pulse side and a 40 MHz APB clock.
`timescale 1ns/1ps
module tb_axis_positioning_control;
  import apc_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e; bit care;} apc_exp_t;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd94, base;
  logic pready, pslverr, tool_load_en = 1'b0, ext_cmd_in = 1'b0, sync_start_i = 1'b0, cw_ccw = 1'b0;
  logic origin_in, dog_in, drive_ready_in, upper_lim_in, lower_lim_in;
  logic sync_start_o, dev_clear_o, pulse_out_a, pulse_out_b, positioning_complete_flag;
  int pos, p0, n_fail = 0, total_checks = 0, cyc = 0;
  apc_exp_t q[$];
  apc_exp_t x;
  always #12.5 pclk = ~pclk;
  apc_axis_ctrl #(.CYC_MS(10)) u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tool_load_en, .origin_in, .dog_in, .drive_ready_in, .upper_lim_in,
    .lower_lim_in, .ext_cmd_in, .sync_start_i, .sync_start_o, .dev_clear_o, .pulse_out_a, .pulse_out_b,
    .positioning_complete_flag);
  apc_drive_model u_drv (.pclk, .cw_ccw, .pulse_out_a, .pulse_out_b, .origin_in, .dog_in, .drive_ready_in,
    .upper_lim_in, .lower_lim_in, .pos);
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic end_of_test;
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1, input logic e = 0);
    q.push_back('{d, m, e, 1'b1});
    apb(1'b0, a, 32'h0);
  endtask : chk
  task automatic feed(input logic [31:0] v);
    chk(OFF_FEED_LO, {16'h0, v[15:0]});
    chk(OFF_FEED_HI, {16'h0, v[31:16]});
  endtask : feed
  task automatic cmp(input logic ok);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t output mismatch", $time);
    end
  endtask : cmp
  task automatic wait_idle;
    int i;
    i = 0;
    rd = 32'h2;
    while (rd[1] === 1'b1 && i < 5000) begin
      q.push_back('{32'h0, 32'h0, 1'b0, 1'b0});
      apb(1'b0, OFF_STATUS, 32'h0);
      i++;
    end
    if (i == 5000) begin
      n_fail++;
      end_of_test();
    end
  endtask : wait_idle
  task automatic go(input logic [2:0] m, input logic [31:0] t, input logic [31:0] s, input logic [31:0] dw);
    apb(1'b1, OFF_METHOD, {29'h0, m});
    apb(1'b1, OFF_SPEED, s);
    apb(1'b1, OFF_TARGET, t);
    apb(1'b1, OFF_DWELL, dw);
    p0 = pos;
    apb(1'b1, OFF_CTRL, 32'h2);
  endtask : go
  // ****
  // Read monitor and timeout
  // ****
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      x = q.pop_front();
      if (x.care) begin
        total_checks++;
        if (((prdata & x.m) !== x.d) || (pslverr !== x.e)) begin
          n_fail++;
          $display("ERROR %0t read %h got %h", $time, paddr, prdata);
        end
      end
    end
    if (cyc == 80000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    tool_load_en <= 1'b1;
    chk(OFF_LIMIT, {14'h0, SPEED_MAX});
    chk(8'h40, 32'h0, '1, 1'b1);
    apb(1'b1, OFF_CFG, 32'h8);
    chk(OFF_GPIO, 32'h45);
    cmp(dev_clear_o === 1'b1);
    apb(1'b1, OFF_LIMIT, 32'd100000);
    apb(1'b1, OFF_BIAS, 32'd100000);
    apb(1'b1, OFF_ACC, 32'h0);
    apb(1'b1, OFF_DEC, 32'h0);
    seed = lfsr(seed);
    base = {12'h0, seed[19:0]};
    go(M_CHG, base, 32'h0, 32'd2);
    chk(OFF_STATUS, 32'h0, 32'h1);
    wait_idle();
    chk(OFF_STATUS, 32'h1, 32'h1);
    cmp(positioning_complete_flag === 1'b1);
    feed(base);
    cmp(pos == p0);
    go(M_NONE, base + 32'd100, 32'd100000, 32'h0);
    repeat (1500) @(posedge pclk);
    feed(base);
    cmp(pos == p0);
    go(M_ABS, base + 32'd20, 32'd200000, 32'h0);
    wait_idle();
    feed(base + 32'd20);
    cmp(pos == p0 + 20);
    apb(1'b1, OFF_CFG, 32'h9);
    cw_ccw <= 1'b1;
    go(M_INC, 32'hfffffff1, 32'h0, 32'h0);
    wait_idle();
    apb(1'b1, OFF_CFG, 32'h8);
    cw_ccw <= 1'b0;
    feed(base + 32'd5);
    cmp(pos == p0 - 15);
    go(M_SPF, 32'd12, 32'd100000, 32'h0);
    repeat (1000) @(posedge pclk);
    cmp(pos > p0);
    ext_cmd_in <= 1'b1;
    wait_idle();
    ext_cmd_in <= 1'b0;
    feed(32'd12);
    chk(OFF_STATUS, 32'h1, 32'h1);
    for (int k = 0; k < 2; k++) begin
      go(k == 0 ? M_SVF : M_SVR, base, 32'd100000, 32'h0);
      repeat (2000) @(posedge pclk);
      cmp(k == 0 ? pos > p0 : pos < p0);
      chk(OFF_STATUS, 32'h2, 32'h2);
      apb(1'b1, OFF_CTRL, 32'h8);
      wait_idle();
      chk(OFF_STATUS, 32'h0, 32'h1);
      cmp(positioning_complete_flag === 1'b0);
    end
    apb(1'b1, OFF_METHOD, {29'h0, M_CHG});
    apb(1'b1, OFF_TSEL, 32'h9);
    apb(1'b1, OFF_TCOMMIT, 32'h0);
    apb(1'b1, OFF_TARGET, 32'h7);
    apb(1'b1, OFF_TSEL, 32'ha);
    apb(1'b1, OFF_TCOMMIT, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h91);
    wait_idle();
    feed(base);
    tool_load_en <= 1'b0;
    go(M_CHG, 32'h3, 32'h0, 32'h0);
    wait_idle();
    apb(1'b1, OFF_TSEL, 32'h9);
    apb(1'b1, OFF_TCOMMIT, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h91);
    wait_idle();
    feed(base);
    go(M_CHG, 32'h3, 32'h0, 32'h0);
    wait_idle();
    apb(1'b1, OFF_CTRL, 32'h94);
    @(negedge pclk);
    cmp(sync_start_o === 1'b1);
    wait_idle();
    feed(base);
    go(M_CHG, 32'h5, 32'h0, 32'h0);
    wait_idle();
    apb(1'b1, OFF_CTRL, 32'h90);
    sync_start_i <= 1'b1;
    repeat (8) @(posedge pclk);
    sync_start_i <= 1'b0;
    wait_idle();
    feed(base);
    end_of_test();
  end
endmodule : tb_axis_positioning_control
